/* File: logic/ppsr_pkg.sv */
// Constants shared by the channel status and reset controller.
// Assumes a single 125 MHz clock and an AXI4-Lite register slave.
package ppsr_pkg;
	// ----------------------------------------------------------------
	// Register byte addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_IRQ_ST = 8'h08;
	localparam logic [7:0] ADDR_IRQ_MK = 8'h0c;
	localparam logic [7:0] ADDR_PHYCNT = 8'h10;

	// ----------------------------------------------------------------
	// Fields and reset values
	// ----------------------------------------------------------------
	localparam int CTRL_INFER_BIT = 0;
	localparam int CTRL_SIMBUSY_BIT = 1;
	localparam int CTRL_RECFG_BIT = 2;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam int IRQ_PHYDONE_BIT = 0;
	localparam int IRQ_BUSYDONE_BIT = 1;
	localparam int IRQ_IDLE_BIT = 2;
	localparam logic [2:0] IRQ_MASK_RESET = 3'h0;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_MHZ = 125;
	localparam int SIM_BUSY_CYCLES = 20;
	localparam int PHY_ACT_NS = 64;
	localparam int PHY_ACT_CYCLES = (PHY_ACT_NS * CLK_MHZ + 999) / 1000;

	localparam logic [1:0] PWR_P0  = 2'b00;
	localparam logic [1:0] PWR_P0S = 2'b01;
	localparam logic [1:0] PWR_P1  = 2'b10;
	localparam logic [1:0] PWR_P2  = 2'b11;

	typedef enum logic [1:0] {PH_IDLE, PH_BUSY, PH_DONE} ppsr_phy_t;
endpackage

/* File: logic/ppsr_top.sv */
// Control and status logic of one serial channel in PHY-interface mode.
// Assumes aclk at 125 MHz, asynchronous control pins, AXI4-Lite master.
// Operation
// - Polarity invert complements every bit of the 10-bit decoder input.
// - Power state is two bits: 00 P0, 01 P0s, 10 P1, 11 P2.
// - Receive-valid rises only while data and control flags are valid.
// - PHY-done pulses exactly one cycle when a PHY function completes.
// - With idle inference enabled, idle output follows the inference result.
// - With inference disabled, idle output is the inverse of signal present.
// - Busy falls to report offset cancellation completed.
// - Busy pulses at power-up, later only on a write that sets the reconfiguration request bit.
// - Simulation busy falls about 20 reconfiguration clock cycles after start.
// - Detection starts with control high in P1 and forced idle; release at done.
module ppsr_top #(
	parameter int BUSY_CYCLES = 4096
)(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        rx_decoder_polarity_invert,
	input  wire logic [1:0]  power_state,
	input  wire logic        detect_loopback,
	input  wire logic        force_elec_idle,
	input  wire logic        rx_signal_present,
	input  wire logic        idle_inferred,
	input  wire logic [9:0]  rx_code_in,
	input  wire logic        rx_code_valid,
	input  wire logic [9:0]  rx_decoder_in,
	output logic [9:0]       rx_decoder_word,
	input  wire logic [15:0] rx_data_in,
	input  wire logic [1:0]  rx_ctrl_in,
	output logic [15:0]      rx_data_out,
	output logic [1:0]       rx_ctrl_out,
	output logic             rx_data_valid,
	output logic             phy_done,
	output logic             rx_elec_idle,
	output logic             power_down_stall,
	output logic             recfg_busy,
	output logic             irq
);
	// ----------------------------------------------------------------
	// Synchronisers
	// ----------------------------------------------------------------
	localparam int NSYNC = 7;
	logic [NSYNC-1:0] async_in;
	logic [NSYNC-1:0] sync1_q;
	logic [NSYNC-1:0] sync2_q;
	assign async_in = {rx_decoder_polarity_invert, power_state, detect_loopback,
		force_elec_idle, rx_signal_present, idle_inferred};

	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi++)
		begin : g_sync
			always_ff @(posedge aclk)
			begin
				if (!aresetn)
				begin
					sync1_q[gi] <= 1'b0;
					sync2_q[gi] <= 1'b0;
				end
				else
				begin
					sync1_q[gi] <= async_in[gi];
					sync2_q[gi] <= sync1_q[gi];
				end
			end
		end
	endgenerate

	logic       pol_s;
	logic [1:0] pwr_s;
	logic       det_s;
	logic       fidle_s;
	logic       sigp_s;
	logic       infer_s;
	assign {pol_s, pwr_s, det_s, fidle_s, sigp_s, infer_s} = sync2_q;

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [31:0] ctrl_q;
	logic [2:0]  irq_st_q;
	logic [2:0]  irq_mk_q;
	logic [15:0] phy_cnt_q;
	logic [2:0]  irq_ev;
	logic        wr_fire;
	logic        aw_hold_q;
	logic        w_hold_q;
	logic [7:0]  awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0]  wstrb_q;

	// ----------------------------------------------------------------
	// Decoder polarity and receive data
	// ----------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			rx_decoder_word <= 10'h000;
		else
			rx_decoder_word <= pol_s ? ~rx_decoder_in : rx_decoder_in;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rx_data_out   <= 16'h0000;
			rx_ctrl_out   <= 2'h0;
			rx_data_valid <= 1'b0;
		end
		else
		begin
			// Data and flags load in the same edge as valid, so they agree
			rx_data_valid <= rx_code_valid;
			if (rx_code_valid)
			begin
				rx_data_out <= rx_data_in;
				rx_ctrl_out <= rx_ctrl_in;
			end
		end
	end

	// ----------------------------------------------------------------
	// Power state and receiver detection
	// ----------------------------------------------------------------
	ppsr_pkg::ppsr_phy_t phy_q;
	logic [1:0]  pwr_q;
	logic [7:0]  act_q;
	logic        det_start;
	assign det_start = det_s && fidle_s && (pwr_s == ppsr_pkg::PWR_P1);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			phy_q <= ppsr_pkg::PH_IDLE;
			pwr_q <= ppsr_pkg::PWR_P0;
			act_q <= 8'h00;
		end
		else
		begin
			case (phy_q)
				ppsr_pkg::PH_IDLE:
				begin
					if (pwr_s != pwr_q || det_start)
					begin
						pwr_q <= pwr_s;
						act_q <= 8'(ppsr_pkg::PHY_ACT_CYCLES);
						phy_q <= ppsr_pkg::PH_BUSY;
					end
				end
				ppsr_pkg::PH_BUSY:
				begin
					if (act_q <= 8'h01)
						phy_q <= ppsr_pkg::PH_DONE;
					else
						act_q <= act_q - 8'h01;
				end
				default:
				begin
					// Wait for the controller to drop detection before rearming
					if (!det_start)
						phy_q <= ppsr_pkg::PH_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			phy_done <= 1'b0;
		else
			phy_done <= (phy_q == ppsr_pkg::PH_BUSY) && (act_q <= 8'h01);
	end

	// ----------------------------------------------------------------
	// Electrical idle
	// ----------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			rx_elec_idle <= 1'b0;
		else if (ctrl_q[ppsr_pkg::CTRL_INFER_BIT])
			rx_elec_idle <= infer_s;
		else
			rx_elec_idle <= ~sigp_s;
	end

	// ----------------------------------------------------------------
	// Offset cancellation busy
	// ----------------------------------------------------------------
	logic [15:0] busy_cnt_q;
	logic        recfg_req;
	logic        busy_end;
	assign recfg_req = wr_fire && awaddr_q == ppsr_pkg::ADDR_CTRL && wstrb_q[0]
		&& wdata_q[ppsr_pkg::CTRL_RECFG_BIT];
	assign busy_end = recfg_busy && busy_cnt_q <= 16'h0001;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			// Power-up cancellation starts straight out of reset
			recfg_busy <= 1'b1;
			busy_cnt_q <= 16'(BUSY_CYCLES);
		end
		else if (busy_end)
			recfg_busy <= 1'b0;
		else if (recfg_busy)
			busy_cnt_q <= busy_cnt_q - 16'h0001;
		else if (recfg_req)
		begin
			recfg_busy <= 1'b1;
			busy_cnt_q <= ctrl_q[ppsr_pkg::CTRL_SIMBUSY_BIT]
				? 16'(ppsr_pkg::SIM_BUSY_CYCLES) : 16'(BUSY_CYCLES);
		end
	end
	// Tells the reset logic to keep power-down low meanwhile
	assign power_down_stall = recfg_busy;

	// ----------------------------------------------------------------
	// Interrupts
	// ----------------------------------------------------------------
	assign irq_ev = {rx_elec_idle && !sigp_s, busy_end, phy_done};
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			irq_st_q <= 3'h0;
		else if (wr_fire && awaddr_q == ppsr_pkg::ADDR_IRQ_ST && wstrb_q[0])
			irq_st_q <= (irq_st_q & ~wdata_q[2:0]) | irq_ev;
		else
			irq_st_q <= irq_st_q | irq_ev;
	end
	assign irq = |(irq_st_q & irq_mk_q);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			phy_cnt_q <= 16'h0000;
		else if (phy_done)
			phy_cnt_q <= phy_cnt_q + 16'h0001;
	end

	// ----------------------------------------------------------------
	// AXI4-Lite write
	// ----------------------------------------------------------------
	assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
	assign s_axi_wready  = !w_hold_q && !s_axi_bvalid;
	assign wr_fire = aw_hold_q && w_hold_q;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_hold_q    <= 1'b0;
			w_hold_q     <= 1'b0;
			awaddr_q     <= 8'h00;
			wdata_q      <= 32'h0;
			wstrb_q      <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= 2'b00;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_hold_q <= 1'b1;
				awaddr_q  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_hold_q <= 1'b1;
				wdata_q  <= s_axi_wdata;
				wstrb_q  <= s_axi_wstrb;
			end
			if (wr_fire)
			begin
				aw_hold_q    <= 1'b0;
				w_hold_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				if (awaddr_q == ppsr_pkg::ADDR_CTRL || awaddr_q == ppsr_pkg::ADDR_IRQ_ST
					|| awaddr_q == ppsr_pkg::ADDR_IRQ_MK)
					s_axi_bresp <= 2'b00;
				else if (awaddr_q == ppsr_pkg::ADDR_STATUS || awaddr_q == ppsr_pkg::ADDR_PHYCNT)
					s_axi_bresp <= 2'b00;
				else
					s_axi_bresp <= 2'b10;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctrl_q   <= ppsr_pkg::CTRL_RESET;
			irq_mk_q <= ppsr_pkg::IRQ_MASK_RESET;
		end
		else if (wr_fire && wstrb_q[0])
		begin
			// Reconfiguration request bit is a trigger and never stored
			if (awaddr_q == ppsr_pkg::ADDR_CTRL)
				ctrl_q <= {30'h0, wdata_q[1:0]};
			else if (awaddr_q == ppsr_pkg::ADDR_IRQ_MK)
				irq_mk_q <= wdata_q[2:0];
		end
	end

	// ----------------------------------------------------------------
	// AXI4-Lite read
	// ----------------------------------------------------------------
	assign s_axi_arready = !s_axi_rvalid;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0;
			s_axi_rresp  <= 2'b00;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= 2'b00;
			if (s_axi_araddr == ppsr_pkg::ADDR_CTRL)
				s_axi_rdata <= ctrl_q;
			else if (s_axi_araddr == ppsr_pkg::ADDR_STATUS)
				s_axi_rdata <= {25'h0, pwr_q, phy_q == ppsr_pkg::PH_BUSY,
					rx_elec_idle, recfg_busy, rx_data_valid, pol_s};
			else if (s_axi_araddr == ppsr_pkg::ADDR_IRQ_ST)
				s_axi_rdata <= {29'h0, irq_st_q};
			else if (s_axi_araddr == ppsr_pkg::ADDR_IRQ_MK)
				s_axi_rdata <= {29'h0, irq_mk_q};
			else if (s_axi_araddr == ppsr_pkg::ADDR_PHYCNT)
				s_axi_rdata <= {16'h0, phy_cnt_q};
			else
			begin
				s_axi_rdata <= 32'h0;
				s_axi_rresp <= 2'b10;
			end
		end
		else if (s_axi_rvalid && s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_done_one_cycle: assert property (@(posedge aclk) disable iff (!aresetn)
		phy_done |=> !phy_done) else $error("phy_done longer than one cycle");
	a_polarity_inv: assert property (@(posedge aclk) disable iff (!aresetn)
		pol_s |=> rx_decoder_word == ~$past(rx_decoder_in)) else $error("polarity not inverted");
	a_idle_direct: assert property (@(posedge aclk) disable iff (!aresetn)
		!ctrl_q[0] |=> rx_elec_idle == !$past(sigp_s)) else $error("idle not inverse");
	a_idle_infer: assert property (@(posedge aclk) disable iff (!aresetn)
		ctrl_q[0] |=> rx_elec_idle == $past(infer_s)) else $error("idle not inferred");
	a_valid_data: assert property (@(posedge aclk) disable iff (!aresetn)
		rx_code_valid |=> rx_data_valid && rx_data_out == $past(rx_data_in))
		else $error("valid without data");
	// Length of the running busy period, and whether it was started in short mode
	logic [15:0] busy_len_q;
	logic        sim_run_q;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			busy_len_q <= 16'h0000;
			sim_run_q  <= 1'b0;
		end
		else if (!recfg_busy)
		begin
			busy_len_q <= 16'h0000;
			sim_run_q  <= recfg_req && ctrl_q[ppsr_pkg::CTRL_SIMBUSY_BIT];
		end
		else
			busy_len_q <= busy_len_q + 16'h0001;
	end

	a_sim_busy: assert property (@(posedge aclk) disable iff (!aresetn)
		$fell(recfg_busy) && sim_run_q |-> busy_len_q == 16'(ppsr_pkg::SIM_BUSY_CYCLES))
		else $error("sim busy length wrong");
	a_busy_trigger: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(recfg_busy) |-> $past(recfg_req)) else $error("busy without request");
	a_detect_done: assert property (@(posedge aclk) disable iff (!aresetn)
		phy_q == ppsr_pkg::PH_IDLE && det_start && pwr_q == pwr_s
		|-> ##[1:10] phy_done) else $error("detect never done");
	a_sync_pwr: assert property (@(posedge aclk) disable iff (!aresetn)
		##2 pwr_s == $past(power_state, 2)) else $error("power state not synchronised");
	c_detect: cover property (@(posedge aclk) disable iff (!aresetn) det_start ##[1:10] phy_done);
	c_busy_end: cover property (@(posedge aclk) disable iff (!aresetn) busy_end);
	c_irq: cover property (@(posedge aclk) disable iff (!aresetn) irq);
endmodule

/* File: sim/ppsr_mac_model.sv */
// Link-layer controller model driving power state and receiver detection.
// Assumes the channel reports each finished request with one phy_done pulse.
module ppsr_mac_model (
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic [1:0] req_state,
	input  wire logic       req_detect,
	input  wire logic       phy_done,
	output logic [1:0]      power_state,
	output logic            detect_loopback,
	output logic            force_elec_idle
);
	timeunit 1ns;
	timeprecision 1ps;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			power_state     <= ppsr_pkg::PWR_P0;
			detect_loopback <= 1'b0;
			force_elec_idle <= 1'b0;
		end
		else
		begin
			power_state     <= req_state;
			force_elec_idle <= (req_state == ppsr_pkg::PWR_P1);
			// Released on completion so that a new detection needs a new request
			if (phy_done)
				detect_loopback <= 1'b0;
			else if (req_detect && power_state == ppsr_pkg::PWR_P1 && force_elec_idle)
				detect_loopback <= 1'b1;
		end
	end
endmodule

/* File: sim/tb_top.sv */
// Self-checking bench for the channel status and reset controller.
// Assumes ppsr_pkg and ppsr_top compiled first; BUSY_CYCLES shortened to 30.
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int BUSY = 30;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0, rdata;
	logic        awready, wready, bvalid, arready, rvalid, irq, busy, stall, dvalid, done, eidle;
	logic [1:0]  bresp, rresp, ctrl_out, pstate;
	logic        inv = 1'b0, sigp = 1'b0, infer = 1'b0, cvalid = 1'b0, det, fidle;
	logic [1:0]  req_state = 2'b00, ctrl_in = 2'b00;
	logic        req_det = 1'b0;
	logic [9:0]  dec_in = 10'h000, dec_word;
	logic [15:0] din = 16'h0000, dout;
	int          fails = 0;
	int          comparisons = 0;

	always #4 aclk = ~aclk;

	ppsr_top #(.BUSY_CYCLES(BUSY)) dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.rx_decoder_polarity_invert(inv), .power_state(pstate), .detect_loopback(det),
		.force_elec_idle(fidle), .rx_signal_present(sigp), .idle_inferred(infer),
		.rx_code_in(dec_in), .rx_code_valid(cvalid), .rx_decoder_in(dec_in),
		.rx_decoder_word(dec_word), .rx_data_in(din), .rx_ctrl_in(ctrl_in),
		.rx_data_out(dout), .rx_ctrl_out(ctrl_out), .rx_data_valid(dvalid), .phy_done(done),
		.rx_elec_idle(eidle), .power_down_stall(stall), .recfg_busy(busy), .irq(irq));

	ppsr_mac_model mac (.aclk(aclk), .aresetn(aresetn), .req_state(req_state),
		.req_detect(req_det), .phy_done(done), .power_state(pstate),
		.detect_loopback(det), .force_elec_idle(fidle));

	// ----------------------------------------------------------------
	// Shared helpers
	// ----------------------------------------------------------------
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		comparisons++;
		if (seen !== exp)
		begin
			fails++;
			$display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge aclk);
	endtask

	task automatic guard(input int n);
		if (n > 200)
		begin
			chk(1'b0, 1'b1, "wait ran out");
			tally_and_finish();
		end
	endtask

	// Samples taken right after the edge see the values the design had at it
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		// One idle edge keeps a new request apart from the previous release
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			n++;
			guard(n);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end
		while (bvalid !== 1'b1);
		bready <= 1'b0;
		chk(bresp, 2'b00, "write response");
	endtask

	task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			n++;
			guard(n);
			if (arready) arvalid <= 1'b0;
		end
		while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask

	// Counts high cycles of the completion pulse over a fixed window
	task automatic done_cycles(output int k);
		k = 0;
		repeat (24)
		begin
			@(posedge aclk);
			if (done === 1'b1) k++;
		end
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_powerup();
		int n;
		logic [31:0] d;
		logic [1:0] r;
		n = 0;
		chk({stall, busy}, 2'b11, "busy and stall after reset");
		while (busy === 1'b1)
		begin
			@(posedge aclk);
			n++;
			guard(n);
		end
		chk(n >= BUSY - 4 && n <= BUSY + 4, 1'b1, "power-up busy length");
		chk(stall, 1'b0, "stall released with busy");
		axr(ppsr_pkg::ADDR_IRQ_MK, d, r);
		chk(d, 32'h0, "mask reset value");
		axr(8'h14, d, r);
		chk({r, d}, {2'b10, 32'h0}, "unmapped read");
		$display("power-up done");
	endtask

	task automatic t_polarity();
		dec_in <= 10'h2a5;
		tick(5);
		chk(dec_word, 10'h2a5, "plain word");
		inv <= 1'b1;
		tick(5);
		chk(dec_word, 10'h15a, "inverted word");
		inv <= 1'b0;
		$display("polarity done");
	endtask

	task automatic t_valid();
		din <= 16'hbeef;
		ctrl_in <= 2'b01;
		cvalid <= 1'b1;
		tick(1);
		cvalid <= 1'b0;
		tick(1);
		chk({dvalid, ctrl_out, dout}, {1'b1, 2'b01, 16'hbeef}, "valid data");
		tick(1);
		chk(dvalid, 1'b0, "valid drops");
		$display("receive valid done");
	endtask

	task automatic t_power();
		int k;
		logic [1:0] st [4] = '{ppsr_pkg::PWR_P0S, ppsr_pkg::PWR_P1,
			ppsr_pkg::PWR_P2, ppsr_pkg::PWR_P0};
		logic [31:0] d;
		logic [1:0] r;
		foreach (st[i])
		begin
			req_state <= st[i];
			done_cycles(k);
			chk(k, 1, "one done pulse per state change");
		end
		req_state <= ppsr_pkg::PWR_P1;
		done_cycles(k);
		chk(k, 1, "one done pulse entering P1");
		req_det <= 1'b1;
		tick(1);
		req_det <= 1'b0;
		done_cycles(k);
		chk(k, 1, "one done pulse per detection");
		chk(det, 1'b0, "detect released");
		axr(ppsr_pkg::ADDR_PHYCNT, d, r);
		chk(d, 32'd6, "completion count");
		req_state <= ppsr_pkg::PWR_P0;
		done_cycles(k);
		chk(k, 1, "one done pulse back to P0");
		$display("power states done");
	endtask

	task automatic t_idle();
		axw(ppsr_pkg::ADDR_CTRL, 32'h0);
		sigp <= 1'b1;
		tick(5);
		chk(eidle, 1'b0, "signal present, no idle");
		sigp <= 1'b0;
		tick(5);
		chk(eidle, 1'b1, "no signal, idle");
		axw(ppsr_pkg::ADDR_CTRL, 32'h1);
		tick(5);
		chk(eidle, 1'b0, "inference clear");
		infer <= 1'b1;
		tick(5);
		chk(eidle, 1'b1, "inference set");
		$display("electrical idle done");
	endtask

	task automatic t_recfg();
		int n;
		logic [31:0] d;
		logic [1:0] r;
		axw(ppsr_pkg::ADDR_IRQ_ST, 32'h7);
		axw(ppsr_pkg::ADDR_IRQ_MK, 32'h2);
		axw(ppsr_pkg::ADDR_CTRL, 32'h3);
		tick(3);
		chk({busy, irq}, 2'b00, "no busy without request");
		axw(ppsr_pkg::ADDR_CTRL, 32'h7);
		n = 0;
		while (busy === 1'b1)
		begin
			@(posedge aclk);
			n++;
			guard(n);
		end
		chk(n >= 16 && n <= 24, 1'b1, "short busy length");
		tick(2);
		chk(irq, 1'b1, "busy-fell interrupt");
		axw(ppsr_pkg::ADDR_IRQ_MK, 32'h0);
		chk(irq, 1'b0, "masked");
		axr(ppsr_pkg::ADDR_IRQ_ST, d, r);
		chk(d[1], 1'b1, "status still set");
		axw(ppsr_pkg::ADDR_IRQ_ST, 32'h2);
		axw(ppsr_pkg::ADDR_IRQ_MK, 32'h2);
		tick(1);
		chk(irq, 1'b0, "cleared");
		$display("reconfiguration busy done");
	endtask

	initial
	begin
		// The bench sequences the only reset itself and never drives block power-down
		tick(10);
		aresetn <= 1'b1;
		tick(1);
		t_powerup();
		t_polarity();
		t_valid();
		t_power();
		t_idle();
		t_recfg();
		tally_and_finish();
	end
endmodule
